// File: logic/tuoc_top.sv
`timescale 1ns/1ps
`default_nettype none
module tuoc_top import tuoc_pkg::*; #(
    parameter int RAMP_CYCLES = RAMP_CYC,
    parameter int OVER_CYCLES = LOAD_OVER_CYC,
    parameter int DEB_CYCLES = DEBOUNCE_CYC
) (
    input wire logic CLK_SYS, // 50 MHz system clock
    input wire logic ARST_N, // Power-on reset, low
    input wire logic BTN_LOAD, // Load pushbutton
    input wire logic BTN_ONLINE, // Online pushbutton
    input wire logic BTN_REWIND, // Rewind pushbutton
    input wire logic BTN_TEST_MODE, // Test mode pushbutton
    input wire logic BTN_STOP, // Test panel stop
    input wire logic BTN_FWD, // Test panel forward run
    input wire logic BTN_REV, // Test panel reverse run
    input wire logic BTN_FAST_FWD, // Test panel fast forward
    input wire logic BTN_FAST_REV, // Test panel fast reverse
    input wire logic BTN_WRITE_TEST, // Test panel write test
    input wire logic SNS_LOAD_POINT, // Load-point marker seen
    input wire logic SNS_EOT, // End-of-tape marker seen
    input wire logic SNS_TENSION, // Tape under tension
    input wire logic SNS_WRITE_RING, // Write-permit ring present
    input wire logic [1:0] UNIT_SWITCH, // Rotary address switch
    input wire logic [UNITS-1:0] UNIT_ADDRESS_LINE, // Select lines
    input wire logic IF_REWIND, // Remote rewind level
    input wire logic IF_READ_SEL, // Remote read status
    input wire logic IF_WRITE_SEL, // Remote write status
    output logic SERVO_EN, // Reel servos on
    output logic CAPSTAN_FWD, // Capstan forward
    output logic CAPSTAN_REV, // Capstan reverse
    output logic CAPSTAN_HIGH, // Capstan high speed
    output logic CAPSTAN_RAMP, // Capstan in start/stop ramp
    output logic WRITE_GATE, // Write test writing
    output logic [TRACKS-1:0] WRITE_FLUX, // Write head levels
    output logic IND_LOAD, // Load lamp
    output logic IND_ONLINE, // Online lamp
    output logic IND_REWIND, // Rewind lamp
    output logic IND_READ, // Read lamp
    output logic IND_WRITE, // Write lamp
    output logic IND_SELECT, // Select lamp
    output logic IND_WRITE_EN, // Write enable lamp
    output logic IND_TEST, // Test mode lamp
    output logic IND_WRITE_TEST, // Write test lamp
    output logic IF_READY, // Ready to controller
    output logic IF_ONLINE, // Online to controller
    output logic IF_REWINDING, // Rewinding to controller
    output logic IF_LOAD_POINT, // At load point to controller
    output logic IF_EOT, // End of tape to controller
    output logic IF_WRITE_ENABLED // Write ring to controller
);
    localparam logic [CNT_W-1:0] RAMP_LAST = CNT_W'(RAMP_CYCLES - 1);
    localparam logic [CNT_W-1:0] RAMP_HI_LAST =
        CNT_W'(RAMP_CYCLES / HIGH_SPEED_RATIO - 1);
    localparam logic [CNT_W-1:0] OVER_LAST = CNT_W'(OVER_CYCLES - 1);
    localparam logic [CNT_W-1:0] CELL_LAST = CNT_W'(WT_CELL_CYC - 1);

    tuoc_state_t state_q;
    logic [CNT_W-1:0] tmr_q;
    logic [CNT_W-1:0] ramp_cnt_q;
    logic [CNT_W-1:0] cell_q;
    logic online_q;
    logic loaded_q;
    logic test_mode_q;
    logic wt_arm_q;
    logic run_fwd_q;
    logic run_high_q;
    logic rew_prev_q;
    logic [SY_W-1:0] async_in;
    logic [SY_W-1:0] meta_q;
    logic [SY_W-1:0] sync_q;
    logic [BTN_N-1:0] press;
    wire [BTN_N-1:0] btn_raw;

    logic at_bot;
    logic at_eot;
    logic tension;
    logic ring;
    logic selected;
    logic act;
    logic load_req;
    logic rew_req;
    logic test_go;
    logic test_end;
    logic rewinding;
    logic ready;
    logic wt_on;
    logic mv_fwd;
    logic mv_rev;
    logic mv_high;

    // Ramp length scales inversely with the speed it starts or stops from
    function automatic logic [CNT_W-1:0] ramp_len(input logic high);
        ramp_len = high ? RAMP_HI_LAST : RAMP_LAST; // see RULE19
    endfunction

    assign btn_raw[BI_LOAD] = BTN_LOAD;
    assign btn_raw[BI_ONLINE] = BTN_ONLINE;
    assign btn_raw[BI_REWIND] = BTN_REWIND;
    assign btn_raw[BI_TEST] = BTN_TEST_MODE;
    assign btn_raw[BI_STOP] = BTN_STOP;
    assign btn_raw[BI_FWD] = BTN_FWD;
    assign btn_raw[BI_REV] = BTN_REV;
    assign btn_raw[BI_FFWD] = BTN_FAST_FWD;
    assign btn_raw[BI_FREV] = BTN_FAST_REV;
    assign btn_raw[BI_WTEST] = BTN_WRITE_TEST;

    tuoc_btn_if #(.N(BTN_N)) btn_bus ();

    tuoc_debounce #(
        .N(BTN_N),
        .DEB_CYCLES(DEB_CYCLES)
    ) u_debounce (
        .clk(CLK_SYS),
        .rst_n(ARST_N),
        .raw(btn_raw),
        .btn(btn_bus.deb)
    );

    assign press = btn_bus.press;

    assign async_in[SY_BOT] = SNS_LOAD_POINT;
    assign async_in[SY_EOT] = SNS_EOT;
    assign async_in[SY_TENS] = SNS_TENSION;
    assign async_in[SY_RING] = SNS_WRITE_RING;
    assign async_in[SY_IFREW] = IF_REWIND;
    assign async_in[SY_RDSEL] = IF_READ_SEL;
    assign async_in[SY_WRSEL] = IF_WRITE_SEL;
    assign async_in[SY_SW +: 2] = UNIT_SWITCH;
    assign async_in[SY_ADDR +: UNITS] = UNIT_ADDRESS_LINE;

    // Switch and select lines share the same two-stage path
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign at_bot = sync_q[SY_BOT];
    assign at_eot = sync_q[SY_EOT];
    assign tension = sync_q[SY_TENS];
    assign ring = sync_q[SY_RING];
    assign selected = sync_q[SY_ADDR + int'(sync_q[SY_SW +: 2])]; // see RULE16
    assign act = online_q & selected; // see RULE5, RULE20

    assign load_req = press[BI_LOAD] & ~online_q; // see RULE11
    // Remote rewind is edge triggered so a held level rewinds once
    assign rew_req = (press[BI_REWIND] & ~online_q & tension) | // see RULE7, RULE11
        (act & sync_q[SY_IFREW] & ~rew_prev_q); // see RULE20
    assign test_go = test_mode_q & ~online_q & (press[BI_FWD] |
        press[BI_REV] | press[BI_FFWD] | press[BI_FREV]); // see RULE17
    assign test_end = press[BI_STOP] | online_q |
        (run_fwd_q & at_eot) | (~run_fwd_q & at_bot);
    assign rewinding = (state_q == ST_REWIND) | (state_q == ST_UNLOAD);
    assign ready = loaded_q & tension & (state_q == ST_STOP); // see RULE5
    assign wt_on = wt_arm_q & ring & (state_q == ST_TEST) & run_fwd_q &
        ~run_high_q;

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            rew_prev_q <= 1'b0;
        end else begin
            rew_prev_q <= sync_q[SY_IFREW];
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            online_q <= 1'b0; // see RULE1
        end else if (press[BI_ONLINE]) begin
            online_q <= ~online_q; // see RULE4
        end
    end

    // Tape sequence
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q <= ST_UNTENS; // see RULE1
            tmr_q <= '0;
        end else begin
            unique case (state_q)
                ST_UNTENS: begin
                    if (load_req) begin
                        state_q <= ST_SEEK; // see RULE2
                    end
                end
                ST_SEEK: begin
                    if (at_bot) begin
                        state_q <= ST_OVER;
                        tmr_q <= OVER_LAST;
                    end
                end
                ST_OVER: begin
                    if (tmr_q == '0) begin
                        state_q <= ST_STOP; // see RULE2
                    end else begin
                        tmr_q <= tmr_q - 1'b1;
                    end
                end
                ST_STOP: begin
                    if (!tension) begin
                        state_q <= ST_UNTENS;
                    end else if (rew_req) begin
                        state_q <= at_bot ? ST_UNLOAD : ST_REWIND; // see RULE10
                    end else if (test_go) begin
                        state_q <= ST_TEST;
                    end
                end
                ST_REWIND: begin
                    if (!tension) begin
                        state_q <= ST_UNTENS;
                    end else if (at_bot) begin
                        state_q <= ST_OVER; // see RULE9
                        tmr_q <= OVER_LAST;
                    end
                end
                ST_UNLOAD: begin
                    if (!tension) begin
                        state_q <= ST_UNTENS; // see RULE10
                    end
                end
                ST_TEST: begin
                    if (!tension) begin
                        state_q <= ST_UNTENS;
                    end else if (test_end) begin
                        state_q <= ST_STOP;
                    end
                end
                default: state_q <= ST_UNTENS;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            loaded_q <= 1'b0;
        end else if (state_q == ST_UNTENS || state_q == ST_UNLOAD) begin
            loaded_q <= 1'b0;
        end else if (state_q == ST_OVER && tmr_q == '0) begin
            loaded_q <= 1'b1;
        end
    end

    // Test panel runs only offline and from a stopped, tensioned tape
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            test_mode_q <= 1'b0;
            wt_arm_q <= 1'b0;
            run_fwd_q <= 1'b0;
            run_high_q <= 1'b0;
        end else begin
            if (online_q || state_q == ST_UNTENS) begin
                test_mode_q <= 1'b0;
            end else if (press[BI_TEST] && state_q == ST_STOP) begin
                test_mode_q <= ~test_mode_q;
            end
            if (!test_mode_q) begin
                wt_arm_q <= 1'b0;
            end else if (press[BI_WTEST] && state_q == ST_STOP) begin
                wt_arm_q <= ~wt_arm_q;
            end
            if (test_go && state_q == ST_STOP) begin
                run_fwd_q <= press[BI_FWD] | press[BI_FFWD]; // see RULE17
                run_high_q <= press[BI_FFWD] | press[BI_FREV];
            end
        end
    end

    always_comb begin
        mv_fwd = 1'b0;
        mv_rev = 1'b0;
        mv_high = 1'b0;
        unique case (state_q)
            ST_UNTENS, ST_STOP: begin
            end
            ST_SEEK, ST_OVER: begin
                mv_fwd = 1'b1; // see RULE2, RULE9
            end
            ST_REWIND, ST_UNLOAD: begin
                mv_rev = 1'b1;
                mv_high = 1'b1;
            end
            ST_TEST: begin
                mv_fwd = run_fwd_q;
                mv_rev = ~run_fwd_q;
                mv_high = run_high_q;
            end
            default: begin
            end
        endcase
    end

    // Any change of motion restarts the ramp; a stop ramps from old speed
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            SERVO_EN <= 1'b0; // see RULE1
            CAPSTAN_FWD <= 1'b0;
            CAPSTAN_REV <= 1'b0;
            CAPSTAN_HIGH <= 1'b0;
            CAPSTAN_RAMP <= 1'b0;
            ramp_cnt_q <= '0;
        end else begin
            SERVO_EN <= state_q != ST_UNTENS; // see RULE2, RULE10
            if ({mv_fwd, mv_rev, mv_high} !=
                {CAPSTAN_FWD, CAPSTAN_REV, CAPSTAN_HIGH}) begin
                CAPSTAN_FWD <= mv_fwd;
                CAPSTAN_REV <= mv_rev;
                CAPSTAN_HIGH <= mv_high;
                CAPSTAN_RAMP <= 1'b1;
                ramp_cnt_q <= ramp_len(mv_high | (CAPSTAN_HIGH &
                    ~(mv_fwd | mv_rev))); // see RULE19
            end else if (ramp_cnt_q != '0) begin
                ramp_cnt_q <= ramp_cnt_q - 1'b1;
            end else begin
                CAPSTAN_RAMP <= 1'b0;
            end
        end
    end

    // One flux reversal per cell gives ones on every track
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            cell_q <= '0;
            WRITE_FLUX <= '0;
            WRITE_GATE <= 1'b0;
        end else begin
            WRITE_GATE <= wt_on;
            if (!wt_on) begin
                cell_q <= '0;
            end else if (cell_q == CELL_LAST) begin
                cell_q <= '0;
                WRITE_FLUX <= ~WRITE_FLUX; // see RULE18
            end else begin
                cell_q <= cell_q + 1'b1;
            end
        end
    end

    assign IND_ONLINE = online_q; // see RULE6
    assign IND_TEST = test_mode_q;
    assign IND_WRITE_TEST = wt_arm_q;

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            IND_LOAD <= 1'b0;
            IND_REWIND <= 1'b0;
            IND_READ <= 1'b0;
            IND_WRITE <= 1'b0;
            IND_SELECT <= 1'b0;
            IND_WRITE_EN <= 1'b0;
        end else begin
            IND_LOAD <= (state_q != ST_UNTENS) & tension; // see RULE3
            IND_REWIND <= rewinding; // see RULE8
            IND_READ <= act & sync_q[SY_RDSEL] & ~sync_q[SY_WRSEL]; // see RULE12
            IND_WRITE <= act & sync_q[SY_WRSEL] & ring; // see RULE13
            IND_SELECT <= act; // see RULE14
            IND_WRITE_EN <= ring; // see RULE15
        end
    end

    // Controller sees nothing unless this unit is online and addressed
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            IF_READY <= 1'b0;
            IF_ONLINE <= 1'b0;
            IF_REWINDING <= 1'b0;
            IF_LOAD_POINT <= 1'b0;
            IF_EOT <= 1'b0;
            IF_WRITE_ENABLED <= 1'b0;
        end else begin
            IF_READY <= act & ready; // see RULE5, RULE21
            IF_ONLINE <= act; // see RULE21
            IF_REWINDING <= act & rewinding; // see RULE21
            IF_LOAD_POINT <= act & at_bot & tension; // see RULE21
            IF_EOT <= act & at_eot; // see RULE21
            IF_WRITE_ENABLED <= act & ring; // see RULE21
        end
    end
endmodule
`default_nettype wire

// File: logic/tuoc_pkg.sv
// Operation
// RULE1 - At power-on all motors are off and key control flops are reset.
// RULE2 - Load request tensions tape, runs forward to load point, then stops.
// RULE3 - Load indicator lit while reel servos run and tape is tensioned.
// RULE4 - Each online pushbutton press toggles between online and offline.
// RULE5 - Online unit is remotely selectable; ready only when loaded at/past load point.
// RULE6 - Online indicator lit exactly while the unit is online.
// RULE7 - Local rewind accepted only when tensioned and offline, else ignored.
// RULE8 - Rewind indicator lit during any rewind, local or remote.
// RULE9 - Rewind reaching load point stops and reloads, ending 0.19 inch past marker.
// RULE10 - Rewind requested at load point unloads tape fully and drops tension.
// RULE11 - Local load and rewind buttons are ignored while online.
// RULE12 - Read indicator lit only when online, selected and in read status.
// RULE13 - Write indicator needs online, selected, write status and write ring.
// RULE14 - Select indicator lit whenever online and selected.
// RULE15 - Write-enable indicator follows the write ring, whatever the online state.
// RULE16 - Controller drives the address line matching the rotary switch; unit becomes selected.
// RULE17 - Offline test panel runs tape forward or reverse, normal or high speed.
// RULE18 - Write test writes a crystal-timed all-ones pattern on all tracks.
// RULE19 - Start and stop ramps last 15 ms at 25 ips, inverse to speed.
// RULE20 - Interface inputs are acted on only while online and selected.
// RULE21 - Interface outputs are held false when offline or not selected.
// RULE22 - Each pushbutton is synchronised, debounced and yields one single-cycle pulse.
package tuoc_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int CNT_W = 24;
    localparam int TRACKS = 9;
    localparam int UNITS = 4;
    localparam int NORMAL_IPS = 25;
    localparam int HIGH_SPEED_RATIO = 4;
    localparam int RAMP_TIME_MS = 15;
    localparam int RAMP_CYC = RAMP_TIME_MS * (CLK_HZ / 1000);
    localparam int LOAD_OVER_MILS = 190;
    localparam int LOAD_OVER_CYC =
        LOAD_OVER_MILS * (CLK_HZ / 1000) / NORMAL_IPS;
    localparam int DEBOUNCE_MS = 5;
    localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
    localparam int WT_FLUX_HZ = 20_000;
    localparam int WT_CELL_CYC = CLK_HZ / WT_FLUX_HZ;
    localparam int BI_LOAD = 0;
    localparam int BI_ONLINE = 1;
    localparam int BI_REWIND = 2;
    localparam int BI_TEST = 3;
    localparam int BI_STOP = 4;
    localparam int BI_FWD = 5;
    localparam int BI_REV = 6;
    localparam int BI_FFWD = 7;
    localparam int BI_FREV = 8;
    localparam int BI_WTEST = 9;
    localparam int BTN_N = 10;
    localparam int SY_BOT = 0;
    localparam int SY_EOT = 1;
    localparam int SY_TENS = 2;
    localparam int SY_RING = 3;
    localparam int SY_IFREW = 4;
    localparam int SY_RDSEL = 5;
    localparam int SY_WRSEL = 6;
    localparam int SY_SW = 7;
    localparam int SY_ADDR = 9;
    localparam int SY_W = 13;
    typedef enum logic [2:0] {
        ST_UNTENS = 3'h0,
        ST_SEEK = 3'h1,
        ST_OVER = 3'h2,
        ST_STOP = 3'h3,
        ST_REWIND = 3'h4,
        ST_UNLOAD = 3'h5,
        ST_TEST = 3'h6
    } tuoc_state_t;
endpackage

// File: logic/tuoc_btn_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tuoc_btn_if #(parameter int N = 1);
    wire [N-1:0] press;
    modport deb (output press);
    modport ctl (input press);
endinterface
`default_nettype wire

// File: logic/tuoc_debounce.sv
`timescale 1ns/1ps
`default_nettype none
module tuoc_debounce import tuoc_pkg::*; #(
    parameter int N = 1,
    parameter int DEB_CYCLES = DEBOUNCE_CYC
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Async reset, low
    input wire logic [N-1:0] raw, // Raw buttons, high = pressed
    tuoc_btn_if.deb btn // Press pulses
);
    localparam logic [CNT_W-1:0] DEB_LAST = CNT_W'(DEB_CYCLES - 1);

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_btn
            logic meta_q;
            logic sync_q;
            logic stable_q;
            logic press_q;
            logic [CNT_W-1:0] cnt_q;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= raw[i];
                    sync_q <= meta_q; // see RULE22
                end
            end
            // Level must hold for the whole window; bounces restart it
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    stable_q <= 1'b0;
                    press_q <= 1'b0;
                    cnt_q <= '0;
                end else begin
                    press_q <= 1'b0;
                    if (sync_q == stable_q) begin
                        cnt_q <= '0;
                    end else if (cnt_q == DEB_LAST) begin
                        cnt_q <= '0;
                        stable_q <= sync_q;
                        press_q <= sync_q; // see RULE22
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
            end
            assign btn.press[i] = press_q;
        end
    endgenerate
endmodule
`default_nettype wire

// File: dv/tuoc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tuoc_chk import tuoc_pkg::*; #(
    parameter int RAMP_CYCLES = RAMP_CYC
) (
    input wire logic CLK_SYS, // Clock
    input wire logic ARST_N, // Reset, low
    input wire logic SERVO_EN, // Servos
    input wire logic CAPSTAN_REV, // Reverse
    input wire logic CAPSTAN_HIGH, // High speed
    input wire logic CAPSTAN_RAMP, // Ramp
    input wire logic WRITE_GATE, // Writing
    input wire logic [TRACKS-1:0] WRITE_FLUX, // Head levels
    input wire logic IND_LOAD, // Lamp
    input wire logic IND_ONLINE, // Lamp
    input wire logic IND_REWIND, // Lamp
    input wire logic IND_READ, // Lamp
    input wire logic IND_WRITE, // Lamp
    input wire logic IND_SELECT, // Lamp
    input wire logic IND_WRITE_EN, // Lamp
    input wire logic IF_READY, // To controller
    input wire logic IF_ONLINE // To controller
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!ARST_N);
    int run_q;
    // Reload mid-ramp adds the new ramp's length to the cycles already ramped
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) run_q <= 0;
        else run_q <= CAPSTAN_RAMP ? run_q + 1 : 0;
    end
    sequence s_rew; CAPSTAN_REV && CAPSTAN_HIGH && SERVO_EN; endsequence
    sequence s_quiet; !(IF_READY || IF_ONLINE); endsequence
    property p_load; IND_LOAD |-> SERVO_EN || $past(SERVO_EN); endproperty
    property p_online; IF_ONLINE |-> IND_ONLINE || $past(IND_ONLINE);
    endproperty
    property p_read; IND_READ |-> IND_SELECT && $past(IND_ONLINE);
    endproperty
    property p_write; IND_WRITE |-> IND_SELECT && IND_WRITE_EN; endproperty
    property p_quiet; !IND_SELECT && !$past(IND_SELECT) |-> s_quiet;
    endproperty
    property p_rew; $rose(IND_REWIND) |-> ##[0:2] s_rew; endproperty
    property p_ready; IF_READY |-> IND_SELECT && IND_LOAD; endproperty
    property p_gate; WRITE_GATE |-> !CAPSTAN_HIGH && IND_WRITE_EN
        && (&WRITE_FLUX || !(|WRITE_FLUX)); endproperty
    property p_ramp; $fell(CAPSTAN_RAMP) |-> run_q == RAMP_CYCLES
        || run_q == RAMP_CYCLES / HIGH_SPEED_RATIO
        || run_q > RAMP_CYCLES + 1; endproperty
    a_load: assert property (p_load) else $error("load lamp");
    a_online: assert property (p_online) else $error("online");
    a_read: assert property (p_read) else $error("read lamp");
    a_write: assert property (p_write) else $error("write lamp");
    a_quiet: assert property (p_quiet) else $error("outputs");
    a_rew: assert property (p_rew) else $error("rewind");
    a_ready: assert property (p_ready) else $error("ready");
    a_gate: assert property (p_gate) else $error("write test");
    a_ramp: assert property (p_ramp) else $error("ramp");
endmodule
bind tuoc_top tuoc_chk #(.RAMP_CYCLES(RAMP_CYCLES)) i_chk (.*);
`default_nettype wire

// File: dv/tuoc_tape_model.sv
`timescale 1ns/1ps
`default_nettype none
module tuoc_tape_model (
    input wire logic CLK_SYS, // Clock
    input wire logic ARST_N, // Reset, low
    input wire logic SERVO_EN, // Servos on
    input wire logic CAPSTAN_FWD, // Forward
    input wire logic CAPSTAN_REV, // Reverse
    output logic SNS_LOAD_POINT, // Marker seen
    output logic SNS_EOT, // Far marker
    output logic SNS_TENSION // Tensioned
);
    int pos;
    logic thr;
    // One step a cycle; marker wide enough to hold the load overshoot
    always @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N || !SERVO_EN) begin
            pos <= 0;
            thr <= 1'h1;
        end else if (CAPSTAN_FWD) begin
            pos <= pos + 1;
        end else if (CAPSTAN_REV) begin
            pos <= pos - 1;
            thr <= pos > 1;
        end
    end
    assign SNS_TENSION = SERVO_EN && thr;
    assign SNS_LOAD_POINT = pos >= 60 && pos <= 200;
    assign SNS_EOT = pos >= 5000;
endmodule
`default_nettype wire

// File: dv/tape_unit_operator_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module tape_unit_operator_control_bench import tuoc_pkg::*;;
    logic CLK_SYS = 1'h0, ARST_N = 1'h0, SNS_WRITE_RING = 1'h0;
    logic IF_REWIND = 1'h0, IF_READ_SEL = 1'h0, IF_WRITE_SEL = 1'h0;
    logic [1:0] UNIT_SWITCH = 2'h2;
    logic [UNITS-1:0] UNIT_ADDRESS_LINE = 4'h0;
    logic [BTN_N-1:0] btn = 10'h000;
    wire logic BTN_LOAD, BTN_ONLINE, BTN_REWIND, BTN_TEST_MODE, BTN_STOP;
    wire logic BTN_FWD, BTN_REV, BTN_FAST_FWD, BTN_FAST_REV, BTN_WRITE_TEST;
    wire logic SNS_LOAD_POINT, SNS_EOT, SNS_TENSION, WRITE_GATE;
    wire logic SERVO_EN, CAPSTAN_FWD, CAPSTAN_REV, CAPSTAN_HIGH, CAPSTAN_RAMP;
    wire logic IND_LOAD, IND_ONLINE, IND_REWIND, IND_READ, IND_WRITE;
    wire logic IND_SELECT, IND_WRITE_EN, IND_TEST, IND_WRITE_TEST, IF_EOT;
    wire logic IF_READY, IF_ONLINE, IF_REWINDING, IF_LOAD_POINT;
    wire logic IF_WRITE_ENABLED;
    wire logic [TRACKS-1:0] WRITE_FLUX;
    int failures = 0, samples_checked = 0, n;
    int runs[4] = '{BI_FWD, BI_FFWD, BI_REV, BI_FREV};
    assign {BTN_WRITE_TEST, BTN_FAST_REV, BTN_FAST_FWD, BTN_REV, BTN_FWD,
        BTN_STOP, BTN_TEST_MODE, BTN_REWIND, BTN_ONLINE, BTN_LOAD} = btn;
    tuoc_top #(.RAMP_CYCLES(40), .OVER_CYCLES(20), .DEB_CYCLES(4)) i_dut (.*);
    tuoc_tape_model i_tape (.*);
    initial forever #10 CLK_SYS = ~CLK_SYS;
    task automatic check(input logic v, input logic e);
        samples_checked++;
        if (v !== e) begin
            failures++;
            $display("[FAIL] %0t: got %b, expected %b", $time, v, e);
        end
    endtask
    task automatic summarize();
        if (failures == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge CLK_SYS);
        #1;
    endtask
    task automatic bound();
        tick(1);
        n++;
        if (n > 3000) failures++;
        if (n > 3000) summarize();
    endtask
    // Held well past the debounce time, so one press must give one pulse
    task automatic press(input int b);
        btn[b] = 1'h1;
        tick(12);
        btn[b] = 1'h0;
        tick(12);
    endtask
    task automatic settle();
        n = 0;
        while ((CAPSTAN_FWD | CAPSTAN_REV | CAPSTAN_RAMP) !== 1'h0) bound();
    endtask
    initial begin
        tick(3);
        ARST_N = 1'h1;
        tick(2);
        check(SERVO_EN, 1'h0);
        check(IND_ONLINE, 1'h0);
        press(BI_REWIND);
        check(IND_REWIND, 1'h0);
        SNS_WRITE_RING = 1'h1;
        press(BI_LOAD);
        settle();
        check(SNS_LOAD_POINT, 1'h1);
        check(IND_LOAD, 1'h1);
        check(IND_WRITE_EN, 1'h1);
        press(BI_ONLINE);
        check(IND_ONLINE, 1'h1);
        UNIT_ADDRESS_LINE = 4'h4;
        tick(6);
        check(IND_SELECT, 1'h1);
        check(IF_READY, 1'h1);
        check(IF_LOAD_POINT & IF_WRITE_ENABLED, 1'h1);
        IF_READ_SEL = 1'h1;
        UNIT_ADDRESS_LINE = 4'h2;
        tick(6);
        check(IF_ONLINE, 1'h0);
        check(IF_READY | IF_LOAD_POINT, 1'h0);
        check(IND_READ, 1'h0);
        UNIT_ADDRESS_LINE = 4'h4;
        tick(6);
        check(IND_READ, 1'h1);
        IF_READ_SEL = 1'h0;
        IF_WRITE_SEL = 1'h1;
        tick(6);
        check(IND_WRITE, 1'h1);
        IF_WRITE_SEL = 1'h0;
        press(BI_REWIND);
        check(IND_REWIND, 1'h0);
        for (int i = 0; i < 2; i++) begin
            UNIT_ADDRESS_LINE = i ? 4'h4 : 4'h1;
            IF_REWIND = 1'h1;
            tick(8);
            IF_REWIND = 1'h0;
            // Low long enough that the next raise is a fresh edge
            tick(3);
            check(IND_REWIND, i[0]);
        end
        check(IF_REWINDING, 1'h1);
        n = 0;
        while (SERVO_EN !== 1'h0) bound();
        check(IND_LOAD, 1'h0);
        press(BI_ONLINE);
        check(IND_ONLINE, 1'h0);
        press(BI_LOAD);
        settle();
        check(IND_LOAD, 1'h1);
        press(BI_TEST);
        check(IND_TEST, 1'h1);
        press(BI_WTEST);
        check(IND_WRITE_TEST, 1'h1);
        for (int i = 0; i < 4; i++) begin
            press(runs[i]);
            check(CAPSTAN_FWD, i < 2);
            check(CAPSTAN_REV, i > 1);
            check(CAPSTAN_HIGH, i[0]);
            if (i == 0) begin
                check(WRITE_GATE, 1'h1);
                check(WRITE_FLUX == {TRACKS{WRITE_FLUX[0]}}, 1'h1);
                n = 0;
                while (WRITE_FLUX !== {TRACKS{1'h1}}) bound();
                check(&WRITE_FLUX, 1'h1);
            end
            press(BI_STOP);
            settle();
        end
        press(BI_TEST);
        check(IND_TEST, 1'h0);
        press(BI_REWIND);
        check(CAPSTAN_REV, 1'h1);
        check(IND_REWIND, 1'h1);
        settle();
        check(IND_REWIND, 1'h0);
        check(IND_LOAD, 1'h1);
        summarize();
    end
endmodule
`default_nettype wire
